/* rtl/spsch_consts.svh */
// Register map, field layout and reset values of the polling scheduler.
`ifndef SPSCH_CONSTS_SVH
`define SPSCH_CONSTS_SVH
// Operation
// R1: Continuous search in constant mode restarts at config A channel 1.
// R2: Software enables continuous search only with constant on/off mode.
// R3: Without active/idle, a new polling cycle starts every master period.
// R4: Active/idle runs active periods, then suppresses idle periods.
// R5: Active/idle skipping works the same in every polling mode.
// R6: Control bit 3 enables continuous search during the on time.
// R7: Control bit 2 enables active/idle period skipping.
// R8: Bits 1:0 pick constant, fast fall back or mixed polling mode.
// R9: Off time is ticks times count; low count byte from register one.
// R10: Off-time count bits 13:8 come from bits 5:0 of register two.
// R11: Counts 1 to 3FFFh give that many ticks; zero gives 16384.
// R12: Active count bits 4:0; 1 to 31 periods, zero means 256.
// R13: Idle count bits 7:0; 1 to 255 periods, zero means 256.
// R14: The run pin is high whenever the receiver is active.
// R15: The run pin may instead carry received data in transparent mode.
// R16: Pin-function bit 0 selects receiver-active (0) or data (1).
// R17: Fast fall back bounds the whole search by the config A on timer.
// R18: Off time counts reference tick pulses from a separate prescaler.
// R19: Control registers are write-only and reset to printed values.

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define SPSCH_ADDR_PIN_FUNC     8'h03
`define SPSCH_ADDR_MODE_CTRL    8'h07
`define SPSCH_ADDR_REF_TIMER    8'h08
`define SPSCH_ADDR_OFF_LOW      8'h09
`define SPSCH_ADDR_OFF_HIGH     8'h0A
`define SPSCH_ADDR_ACTIVE       8'h0B
`define SPSCH_ADDR_IDLE         8'h0C
`define SPSCH_ADDR_STATUS       8'h0E
// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SPSCH_BIT_CONT_SEARCH   3
`define SPSCH_BIT_ACTIVE_IDLE   2
`define SPSCH_BIT_PIN_FUNC      0
`define SPSCH_RST_MODE_CTRL     8'h00
`define SPSCH_RST_REF_TIMER     8'h01
`define SPSCH_RST_OFF_LOW       8'h01
`define SPSCH_RST_OFF_HIGH      8'h00
`define SPSCH_RST_ACTIVE        8'h01
`define SPSCH_RST_IDLE          8'h01
`define SPSCH_RST_PIN_FUNC      8'h00
`define SPSCH_OFF_MAX           15'h4000
`define SPSCH_PERIOD_MAX        9'h100
`endif

/* rtl/spsch_pkg.sv */
// Types and shared decoding of the polling scheduler.
package spsch_pkg;

    // Polling mode select codes; code 11b is handled as constant mode.
    typedef enum logic [1:0] {
        SPSCH_MODE_CONST = 2'h0,
        SPSCH_MODE_FAST  = 2'h1,
        SPSCH_MODE_MIXED = 2'h2,
        SPSCH_MODE_RSVD  = 2'h3
    } spsch_mode_t;

    // Scheduler states, one-hot.
    typedef enum logic [3:0] {
        SPSCH_ST_STOP  = 4'h1,
        SPSCH_ST_ON    = 4'h2,
        SPSCH_ST_SLEEP = 4'h4,
        SPSCH_ST_OFF   = 4'h8
    } spsch_state_t;

    // Decoded polling mode control fields.
    typedef struct packed {
        logic        continuous_search_enable;
        logic        active_idle_enable;
        spsch_mode_t polling_mode_select;
    } spsch_ctrl_t;

    // A zero period count stands for the largest count, 256.
    function automatic logic [8:0] spsch_period_len(input logic [7:0] v);
        spsch_period_len = (v == 8'h00) ? 9'h100 : {1'b0, v};
    endfunction : spsch_period_len

endpackage : spsch_pkg

/* rtl/spsch_off_timer.sv */
// Off-time counter driven by reference tick pulses.
`timescale 1ns/1ns
`include "spsch_consts.svh"
module spsch_off_timer
    import spsch_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        ref_tick,
    input  wire logic [13:0] off_time_count,
    output logic             done
);
    logic [14:0] remaining;
    logic        running;

    // Load on start; a zero count stands for the full 16384 ticks.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            remaining <= 15'h0000;
            running   <= 1'b0;
        end else if (start) begin
            remaining <= (off_time_count == 14'h0000) ? `SPSCH_OFF_MAX
                         : {1'b0, off_time_count};  // see R11
            running   <= 1'b1;
        end else if (running && ref_tick) begin
            remaining <= remaining - 15'h0001;  // see R18
            running   <= (remaining != 15'h0001);
        end
    end

    // Done pulses on the tick that consumes the last count.
    assign done = running && ref_tick && (remaining == 15'h0001);

endmodule : spsch_off_timer

/* rtl/spsch_period_gate.sv */
// Active and idle master period counter.
`timescale 1ns/1ns
module spsch_period_gate
    import spsch_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       enable,
    input  wire logic       period_end,
    input  wire logic [4:0] active_period_count,
    input  wire logic [7:0] idle_period_count,
    output logic            period_active
);
    logic       idle_phase;
    logic [8:0] left;

    // Count periods in the current phase and flip phase at the end.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idle_phase <= 1'b0;
            left       <= 9'h001;
        end else if (!enable) begin
            idle_phase <= 1'b0;  // see R3
            left       <= spsch_period_len({3'h0, active_period_count});
        end else if (period_end) begin
            if (left == 9'h001) begin
                idle_phase <= !idle_phase;  // see R4
                left       <= idle_phase
                    ? spsch_period_len({3'h0, active_period_count})  // see R12
                    : spsch_period_len(idle_period_count);  // see R13
            end else begin
                left <= left - 9'h001;
            end
        end
    end

    // On the last period end of a phase, show the phase being entered.
    // Otherwise the receiver would wake for one cycle into an idle period.
    assign period_active = !enable
        || ((period_end && (left == 9'h001)) ? idle_phase : !idle_phase);

endmodule : spsch_period_gate

/* rtl/spsch_top.sv */
// Self-polling scheduler of the receiver: registers, sequencing, run pin.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`include "spsch_consts.svh"
module spsch_top
    import spsch_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    // Register port.
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // Reference tick from the prescaler.
    input  wire logic       ref_tick,
    output logic      [7:0] reference_timer_setting,
    // Self polling run request from chip mode control.
    input  wire logic       polling_run,
    // Search sequencer interface.
    input  wire logic       on_time_done,
    input  wire logic       search_done,
    input  wire logic       config_b_active,
    output logic            period_start,
    output logic            restart_search,
    output logic            on_timer_cfg_b,
    output logic            rx_active,
    // Transparent data and the run pin.
    input  wire logic       rx_data,
    output logic            rx_run_pin
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------

    logic [7:0]   mode_ctrl_reg;
    logic [7:0]   ref_timer_reg;
    logic [7:0]   off_low_reg;
    logic [7:0]   off_high_reg;
    logic [7:0]   active_reg;
    logic [7:0]   idle_reg;
    logic [7:0]   pin_func_reg;
    spsch_ctrl_t  ctrl;
    spsch_state_t state;
    spsch_state_t next_state;
    logic [13:0]  off_time_count;
    logic         off_start;
    logic         off_done;
    logic         period_active;
    logic         search_end;
    logic         stay_on;
    logic         go_sleep;
    logic [7:0]   status;

    // Control registers take their reset values and only software
    // writes change them; no write path exists from the hardware side.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_ctrl_reg <= `SPSCH_RST_MODE_CTRL;  // see R19
            ref_timer_reg <= `SPSCH_RST_REF_TIMER;
            off_low_reg   <= `SPSCH_RST_OFF_LOW;
            off_high_reg  <= `SPSCH_RST_OFF_HIGH;
            active_reg    <= `SPSCH_RST_ACTIVE;
            idle_reg      <= `SPSCH_RST_IDLE;
            pin_func_reg  <= `SPSCH_RST_PIN_FUNC;
        end else if (reg_write) begin
            if (reg_addr == `SPSCH_ADDR_MODE_CTRL) begin
                mode_ctrl_reg <= {4'h0, reg_wdata[3:0]};
            end else if (reg_addr == `SPSCH_ADDR_REF_TIMER) begin
                ref_timer_reg <= reg_wdata;
            end else if (reg_addr == `SPSCH_ADDR_OFF_LOW) begin
                off_low_reg <= reg_wdata;
            end else if (reg_addr == `SPSCH_ADDR_OFF_HIGH) begin
                off_high_reg <= {2'h0, reg_wdata[5:0]};
            end else if (reg_addr == `SPSCH_ADDR_ACTIVE) begin
                active_reg <= {3'h0, reg_wdata[4:0]};
            end else if (reg_addr == `SPSCH_ADDR_IDLE) begin
                idle_reg <= reg_wdata;
            end else if (reg_addr == `SPSCH_ADDR_PIN_FUNC) begin
                pin_func_reg <= {7'h00, reg_wdata[0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Field decoding
    // ------------------------------------------------------------------

    // Mode control fields.
    assign ctrl.continuous_search_enable =
        mode_ctrl_reg[`SPSCH_BIT_CONT_SEARCH];  // see R6
    assign ctrl.active_idle_enable =
        mode_ctrl_reg[`SPSCH_BIT_ACTIVE_IDLE];  // see R7
    assign ctrl.polling_mode_select =
        spsch_mode_t'(mode_ctrl_reg[1:0]);  // see R8

    // Fourteen-bit off-time count split over two registers.
    assign off_time_count = {off_high_reg[5:0],  // see R10
                             off_low_reg};  // see R9

    // The prescaler itself lives elsewhere; only its setting goes out.
    assign reference_timer_setting = ref_timer_reg;  // see R18

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------

    // Status word: state one-hot, phase, receiver activity.
    assign status = {2'h0, period_active, rx_active, state};

    // Control registers are write-only and read as zero. Only the status
    // word answers, so software can watch the scheduler without a probe.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            if (reg_addr == `SPSCH_ADDR_STATUS) begin
                reg_rdata <= status;
            end else begin
                reg_rdata <= 8'h00;  // see R19
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Timing helpers
    // ------------------------------------------------------------------

    // Off-time counter; it only advances on reference ticks.
    spsch_off_timer u_off_timer (
        .clock          (clock),
        .rst            (rst),
        .start          (off_start),
        .ref_tick       (ref_tick),
        .off_time_count (off_time_count),
        .done           (off_done)
    );

    // Active and idle period bookkeeping. Every master period ends with
    // the off time, so the gate steps there whatever the polling mode.
    spsch_period_gate u_period_gate (
        .clock               (clock),
        .rst                 (rst),
        .enable              (ctrl.active_idle_enable),
        .period_end          (off_done),  // see R5
        .active_period_count (active_reg[4:0]),
        .idle_period_count   (idle_reg),
        .period_active       (period_active)
    );

    // ------------------------------------------------------------------
    // Search end handling per mode
    // ------------------------------------------------------------------

    // The sequencer reports that its last channel was searched. What
    // happens next depends on the mode; reserved code 11b acts as
    // constant mode so a stray write can never stop the scheduler.
    assign search_end = search_done && period_active;

    // Continuous search only restarts in constant mode; set in another
    // mode it is ignored, since the feature has no meaning there.
    assign stay_on = search_end
        && ctrl.continuous_search_enable
        && ((ctrl.polling_mode_select == SPSCH_MODE_CONST)
            || (ctrl.polling_mode_select == SPSCH_MODE_RSVD));  // see R1 R2

    // Fast fall back sleeps after the last channel; mixed mode does so
    // only in its config B part, config A there keeps constant timing.
    assign go_sleep = search_end
        && ((ctrl.polling_mode_select == SPSCH_MODE_FAST)
            || ((ctrl.polling_mode_select == SPSCH_MODE_MIXED)
                && config_b_active));

    // ------------------------------------------------------------------
    // Scheduler state machine
    // ------------------------------------------------------------------

    // Next state. On time always ends on the on timer, even after an
    // early sleep, so the master period stays constant.
    always_comb begin
        next_state = state;
        case (state)
            SPSCH_ST_STOP: begin
                if (polling_run) begin
                    next_state = SPSCH_ST_ON;
                end
            end
            SPSCH_ST_ON: begin
                if (!polling_run) begin
                    next_state = SPSCH_ST_STOP;
                end else if (on_time_done) begin
                    next_state = SPSCH_ST_OFF;
                end else if (go_sleep) begin
                    next_state = SPSCH_ST_SLEEP;  // see R17
                end
            end
            SPSCH_ST_SLEEP: begin
                if (!polling_run) begin
                    next_state = SPSCH_ST_STOP;
                end else if (on_time_done) begin
                    next_state = SPSCH_ST_OFF;  // see R17
                end
            end
            SPSCH_ST_OFF: begin
                if (!polling_run) begin
                    next_state = SPSCH_ST_STOP;
                end else if (off_done) begin
                    next_state = SPSCH_ST_ON;  // see R3
                end
            end
            default: begin
                next_state = SPSCH_ST_STOP;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= SPSCH_ST_STOP;
        end else begin
            state <= next_state;
        end
    end

    // The off timer is loaded as the on time ends.
    assign off_start = (state != SPSCH_ST_OFF)
        && (next_state == SPSCH_ST_OFF);

    // ------------------------------------------------------------------
    // Sequencer strobes
    // ------------------------------------------------------------------

    // Period start marks every master period, idle ones included, so the
    // on timer keeps running and idle periods last as long as active.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            period_start <= 1'b0;
        end else begin
            period_start <= (state != SPSCH_ST_ON)
                && (next_state == SPSCH_ST_ON);  // see R3
        end
    end

    // Restart at config A channel 1 while the on time still runs.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            restart_search <= 1'b0;
        end else begin
            restart_search <= (state == SPSCH_ST_ON)
                && (next_state == SPSCH_ST_ON)
                && stay_on;  // see R1
        end
    end

    // Only mixed mode hands on timing to config B; fast fall back keeps
    // the config A on timer for the whole search.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            on_timer_cfg_b <= 1'b0;
        end else begin
            on_timer_cfg_b <= (ctrl.polling_mode_select == SPSCH_MODE_MIXED)
                && config_b_active;  // see R17
        end
    end

    // ------------------------------------------------------------------
    // Receiver activity and run pin
    // ------------------------------------------------------------------

    // Receiver is on in an active period's on phase; an idle period
    // suppresses it though the timing still runs.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_active <= 1'b0;
        end else begin
            rx_active <= (next_state == SPSCH_ST_ON)
                && period_active;  // see R4
        end
    end

    // Pin carries activity or, in transparent use, the received data.
    // Registering adds one cycle to the data path but keeps the pin
    // free of decode glitches that could pulse an external amplifier.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_run_pin <= 1'b0;
        end else if (pin_func_reg[`SPSCH_BIT_PIN_FUNC]) begin
            rx_run_pin <= rx_data;  // see R15 R16
        end else begin
            rx_run_pin <= rx_active;  // see R14
        end
    end

endmodule : spsch_top

/* test/spsch_chk.sv */
// Concurrent checks on the polling scheduler's ports.
`timescale 1ns/1ns
module spsch_chk
    import spsch_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] reference_timer_setting,
    input wire logic       on_time_done,
    input wire logic       search_done,
    input wire logic       config_b_active,
    input wire logic       period_start,
    input wire logic       restart_search,
    input wire logic       on_timer_cfg_b,
    input wire logic       rx_active,
    input wire logic       rx_data,
    input wire logic       rx_run_pin
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Shadow of the write-only bits, since they cannot be read back.
    logic [3:0] ctrl_q;
    logic       pin_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q <= 4'h0;
            pin_q  <= 1'b0;
        end else if (reg_write) begin
            if (reg_addr == 8'h07) ctrl_q <= reg_wdata[3:0];
            if (reg_addr == 8'h03) pin_q <= reg_wdata[0];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    rdata_quiet_a: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    ref_timer_a: assert property (reg_write && reg_addr == 8'h08
        |=> reference_timer_setting == $past(reg_wdata))
        else $error("reference timer setting not updated");
    run_pin_a: assert property (1'b1 |=> rx_run_pin ==
        ($past(pin_q) ? $past(rx_data) : $past(rx_active)))
        else $error("run pin shows the wrong source");
    start_pulse_a: assert property ($rose(rx_active) |-> period_start)
        else $error("receiver woke without a period start");
    start_once_a: assert property (period_start |=> !period_start)
        else $error("period start longer than one cycle");
    restart_once_a: assert property (restart_search |=> !restart_search)
        else $error("restart longer than one cycle");
    timer_cfg_a: assert property (on_timer_cfg_b |->
        $past(ctrl_q[1:0] == 2'h2 && config_b_active))
        else $error("config B timer outside mixed config B");
    on_end_a: assert property (on_time_done && rx_active |=> !rx_active)
        else $error("receiver still active after on time");
    fast_sleep_a: assert property (ctrl_q[1:0] == 2'h1 && search_done
        && rx_active |=> !rx_active)
        else $error("fast mode did not fall back to sleep");
    cont_restart_a: assert property (ctrl_q == 4'h8 && search_done
        && rx_active && !on_time_done |=> restart_search && rx_active)
        else $error("continuous search did not restart");
    const_keep_a: assert property (ctrl_q == 4'h0 && search_done
        && rx_active && !on_time_done |=> rx_active && !restart_search)
        else $error("constant mode left the on time early");
endmodule : spsch_chk

bind spsch_top spsch_chk u_chk (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reference_timer_setting(reference_timer_setting),
    .on_time_done(on_time_done), .search_done(search_done),
    .config_b_active(config_b_active), .period_start(period_start),
    .restart_search(restart_search), .on_timer_cfg_b(on_timer_cfg_b),
    .rx_active(rx_active), .rx_data(rx_data), .rx_run_pin(rx_run_pin));

/* test/spsch_top_tb.sv */
// Self-checking bench for the polling scheduler.
`timescale 1ns/1ns
module spsch_top_tb;
    import spsch_pkg::*;
    logic       clock, rst, reg_write, reg_read, ref_tick, polling_run;
    logic       on_time_done, search_done, config_b_active, rx_data;
    logic       period_start, restart_search, on_timer_cfg_b, rx_active;
    logic       rx_run_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, reference_timer_setting, rv;
    int         n_errors = 0;
    int         comparisons = 0;
    int         n_starts = 0;
    int         n_restarts = 0;
    logic [7:0] wo_addr [8] = '{8'h03, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
                                8'h0C, 8'h55};

    spsch_top dut (
        .clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .ref_tick(ref_tick),
        .reference_timer_setting(reference_timer_setting),
        .polling_run(polling_run), .on_time_done(on_time_done),
        .search_done(search_done), .config_b_active(config_b_active),
        .period_start(period_start), .restart_search(restart_search),
        .on_timer_cfg_b(on_timer_cfg_b), .rx_active(rx_active),
        .rx_data(rx_data), .rx_run_pin(rx_run_pin));

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Count pulses so that short outputs are never missed.
    always @(posedge clock) begin
        if (period_start === 1'b1) n_starts++;
        if (restart_search === 1'b1) n_restarts++;
    end

    // ------------------------------------------------------------------
    // Bus and strobe tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so take them then.
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_cyc

    // One-cycle pulse: 0 ends the on time, 1 ends a search, 2 is a tick.
    task automatic strobe(input int k);
        @(posedge clock);
        if (k == 0) on_time_done <= 1'b1;
        else if (k == 1) search_done <= 1'b1;
        else ref_tick <= 1'b1;
        @(posedge clock);
        on_time_done <= 1'b0;
        search_done  <= 1'b0;
        ref_tick     <= 1'b0;
    endtask : strobe

    // The receiver must stay off until the last of n ticks has arrived.
    task automatic off_run(input int n, input logic exp);
        int s;
        s = n_starts;
        repeat (n - 1) strobe(2);
        wait_cyc(4);
        check({7'h00, rx_active}, 8'h00);
        strobe(2);
        wait_cyc(4);
        check({7'h00, rx_active}, {7'h00, exp});
        check(8'(n_starts - s), 8'h01);
    endtask : off_run

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // Watchdog sized well above the longest off time of the run.
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, reg_write, reg_read, ref_tick, polling_run} = 5'h1_0;
        {on_time_done, search_done, config_b_active, rx_data} = 4'h0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        check(reference_timer_setting, 8'h01);
        foreach (wo_addr[i]) begin
            rd(wo_addr[i]);
            check(rv, 8'h00);
        end
        rd(8'h0E);
        check(rv & 8'h1F, 8'h01);
        wr(8'h08, 8'hA5);
        wait_cyc(1);
        check(reference_timer_setting, 8'hA5);
        @(posedge clock);
        rx_data <= 1'b1;
        wr(8'h03, 8'h01);
        wait_cyc(2);
        check({7'h00, rx_run_pin}, 8'h01);
        wr(8'h03, 8'h00);
        wait_cyc(2);
        check({7'h00, rx_run_pin}, 8'h00);
        wr(8'h09, 8'h03);
        @(posedge clock);
        polling_run <= 1'b1;
        wait_cyc(4);
        check(8'(n_starts), 8'h01);
        check({rx_active, rx_run_pin}, 8'h03);
        rd(8'h0E);
        check(rv & 8'h0F, 8'h02);
        strobe(1);
        wait_cyc(3);
        check({rx_active, 7'(n_restarts)}, 8'h80);
        wr(8'h07, 8'h08);
        strobe(1);
        wait_cyc(3);
        check({rx_active, 7'(n_restarts)}, 8'h81);
        strobe(0);
        rd(8'h0E);
        check(rv & 8'h0F, 8'h08);
        off_run(3, 1'b1);
        wr(8'h07, 8'h01);
        strobe(1);
        wait_cyc(3);
        check({7'h00, rx_active}, 8'h00);
        rd(8'h0E);
        check(rv & 8'h0F, 8'h04);
        wr(8'h0A, 8'h01);
        wr(8'h09, 8'h00);
        strobe(0);
        off_run(256, 1'b1);
        wr(8'h07, 8'h02);
        strobe(1);
        wait_cyc(3);
        check({7'h00, rx_active}, 8'h01);
        @(posedge clock);
        config_b_active <= 1'b1;
        wait_cyc(3);
        check({7'h00, on_timer_cfg_b}, 8'h01);
        strobe(1);
        wait_cyc(3);
        check({7'h00, rx_active}, 8'h00);
        @(posedge clock);
        config_b_active <= 1'b0;
        wr(8'h0A, 8'h00);
        strobe(0);
        off_run(16384, 1'b1);
        wr(8'h09, 8'h02);
        wr(8'h0B, 8'hE1);
        wr(8'h0C, 8'h02);
        wr(8'h07, 8'h05);
        for (int i = 0; i < 6; i++) begin
            strobe(0);
            off_run(2, i % 3 == 2);
        end
        tally_and_finish();
    end
endmodule : spsch_top_tb
